// >>> rtl/swr_pkg.sv
package swr_pkg;

  // ----------------------------------------------------------------
  // Widths and status layout
  // ----------------------------------------------------------------
  localparam int WAKE_PINS = 4;
  localparam int IO_PINS = 8;
  localparam int STATUS_TO_BIT = 4;
  localparam int STATUS_PD_BIT = 3;
  localparam logic TO_N_RESET = 1'b1;
  localparam logic PD_N_RESET = 1'b1;
  localparam logic [7:0] WDT_CLEAR_VALUE = 8'h00;
  localparam logic [7:0] WDT_TOP = 8'hFF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  // Oscillator start-up wait after a wake reset (least time, rounds up)
  localparam int OSC_START_NS = 1000;
  localparam int OSC_START_CYCLES = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Nominal watchdog base period from its own timing (longest, rounds down)
  localparam int WDT_BASE_NS = 18000;
  localparam int WDT_BASE_CYCLES = WDT_BASE_NS / CLK_PERIOD_NS;
  localparam int RESET_PULSE_CYCLES = 2;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SWR_RUN = 2'b00,
    SWR_SLEEP = 2'b01,
    SWR_WAKE_RST = 2'b10,
    SWR_OSC_START = 2'b11
  } swr_state_t;

endpackage

// >>> rtl/swr_wdt_if.sv
`timescale 1ns/1ps
`default_nettype none

// Control and time-out between sequencer and watchdog
interface swr_wdt_if;
  logic enable;
  logic clear;
  logic pre_assigned;
  logic [2:0] ps_sel;
  logic timeout;

  modport ctrl (output enable, output clear, output pre_assigned, output ps_sel, input timeout);
  modport wdt (input enable, input clear, input pre_assigned, input ps_sel, output timeout);
endinterface

`default_nettype wire

// >>> rtl/swr_watchdog.sv
`timescale 1ns/1ps
`default_nettype none

module swr_watchdog #(
  parameter int BASE_CYCLES = swr_pkg::WDT_BASE_CYCLES
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  swr_wdt_if.wdt wdt_bus
);

  typedef struct packed {
    logic [15:0] base;
    logic [7:0] pre;
    logic [7:0] cnt;
    logic timeout;
  } swr_wdt_regs_t;

  swr_wdt_regs_t r;
  swr_wdt_regs_t next_r;
  logic tick;
  logic step;
  logic [7:0] mask;

  // ----------------------------------------------------------------
  // Base tick, postscaler and counter
  // ----------------------------------------------------------------
  // Base divider stands in for the watchdog's own oscillator
  always_comb
  begin
    next_r = r;
    next_r.timeout = 1'b0;
    mask = 8'((9'h002 << wdt_bus.ps_sel) - 9'h001);
    tick = (r.base == 16'(BASE_CYCLES - 1));
    step = 1'b0;
    if (!wdt_bus.enable)
    begin
      next_r.base = 16'h0000;
      next_r.pre = 8'h00;
      next_r.cnt = swr_pkg::WDT_CLEAR_VALUE;
    end
    else if (wdt_bus.clear)
    begin
      next_r.base = 16'h0000;
      next_r.cnt = swr_pkg::WDT_CLEAR_VALUE;
      if (wdt_bus.pre_assigned)
      begin
        next_r.pre = 8'h00;
      end
    end
    else
    begin
      next_r.base = tick ? 16'h0000 : r.base + 16'h0001;
      if (tick && wdt_bus.pre_assigned)
      begin
        next_r.pre = r.pre + 8'h01;
        step = ((r.pre | ~mask) == 8'hFF);
      end
      else
      begin
        step = tick;
      end
      if (step)
      begin
        next_r.cnt = r.cnt + 8'h01;
        next_r.timeout = (r.cnt == swr_pkg::WDT_TOP);
      end
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign wdt_bus.timeout = r.timeout;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_wdt_clear_zero: assert property (@(posedge mclk_in) disable iff (reset_in)
    wdt_bus.enable && wdt_bus.clear |=> r.cnt == 8'h00 && !wdt_bus.timeout)
    else $error("watchdog not zero after clear");

endmodule

`default_nettype wire

// >>> rtl/swr_sleep_wake.sv
`timescale 1ns/1ps
`default_nettype none

module swr_sleep_wake #(
  parameter int OSC_CYCLES = swr_pkg::OSC_START_CYCLES,
  parameter int WDT_BASE = swr_pkg::WDT_BASE_CYCLES
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic sleep_instr_in,
  input wire logic watchdog_clear_instr_in,
  input wire logic port_access_in,
  input wire logic [swr_pkg::WAKE_PINS-1:0] wake_pins_in,
  input wire logic master_clear_pin_n_in,
  input wire logic master_clear_enable_in,
  input wire logic watchdog_enable_in,
  input wire logic wake_on_change_enable_in,
  input wire logic prescaler_to_wdt_in,
  input wire logic [2:0] prescale_sel_in,
  input wire logic [swr_pkg::IO_PINS-1:0] core_io_in,
  input wire logic [swr_pkg::IO_PINS-1:0] core_io_oe_in,
  output logic [swr_pkg::IO_PINS-1:0] io_out,
  output logic [swr_pkg::IO_PINS-1:0] io_oe_out,
  output logic master_clear_oe_out,
  output logic osc_drive_en_out,
  output logic sleeping_out,
  output logic device_reset_out,
  output logic core_hold_out,
  output logic timeout_flag_n_out,
  output logic powerdown_flag_n_out,
  output logic wake_change_flag_out,
  output logic [7:0] status_out
);

  typedef struct packed {
    swr_pkg::swr_state_t state;
    logic [swr_pkg::WAKE_PINS-1:0] pin_s1;
    logic [swr_pkg::WAKE_PINS-1:0] pin_s2;
    logic [swr_pkg::WAKE_PINS-1:0] pin_ref;
    logic master_clear_pin_s1;
    logic master_clear_pin_s2;
    logic timeout_flag_n;
    logic powerdown_flag_n;
    logic wake_change_flag;
    logic [swr_pkg::IO_PINS-1:0] io_q;
    logic [swr_pkg::IO_PINS-1:0] oe_q;
    logic master_clear_pin_oe;
    logic [15:0] wait_cnt;
  } swr_regs_t;

  swr_regs_t r;
  swr_regs_t next_r;
  logic master_clear_pin_reset;
  logic pin_change;
  logic wdt_timeout;
  logic wake_any;

  swr_wdt_if wdt_bus ();

  swr_watchdog #(
    .BASE_CYCLES(WDT_BASE)
  ) u_watchdog (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .wdt_bus(wdt_bus)
  );

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  // Only the second synchroniser stage is looked at
  assign master_clear_pin_reset = master_clear_enable_in && !r.master_clear_pin_s2;
  assign pin_change = wake_on_change_enable_in && (r.pin_s2 != r.pin_ref);
  assign wdt_timeout = wdt_bus.timeout;
  assign wake_any = master_clear_pin_reset || wdt_timeout || pin_change;

  // Watchdog control: cleared on sleep entry, by the instruction, and on wake
  assign wdt_bus.enable = watchdog_enable_in;
  assign wdt_bus.pre_assigned = prescaler_to_wdt_in;
  assign wdt_bus.ps_sel = prescale_sel_in;
  assign wdt_bus.clear = (r.state == swr_pkg::SWR_RUN
                          && (sleep_instr_in || watchdog_clear_instr_in))
                         || r.state == swr_pkg::SWR_WAKE_RST;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.pin_s1 = wake_pins_in;
    next_r.pin_s2 = r.pin_s1;
    next_r.master_clear_pin_s1 = master_clear_pin_n_in;
    next_r.master_clear_pin_s2 = r.master_clear_pin_s1;
    next_r.master_clear_pin_oe = 1'b0;
    unique case (r.state)
      swr_pkg::SWR_RUN:
      begin
        next_r.io_q = core_io_in;
        next_r.oe_q = core_io_oe_in;
        if (port_access_in)
        begin
          next_r.pin_ref = r.pin_s2;
        end
        if (master_clear_pin_reset || wdt_timeout)
        begin
          next_r.state = swr_pkg::SWR_WAKE_RST;
          next_r.wait_cnt = 16'h0000;
          if (wdt_timeout)
          begin
            next_r.timeout_flag_n = 1'b0;
          end
        end
        else if (sleep_instr_in)
        begin
          next_r.state = swr_pkg::SWR_SLEEP;
          next_r.timeout_flag_n = 1'b1;
          next_r.powerdown_flag_n = 1'b0;
        end
        else if (watchdog_clear_instr_in)
        begin
          next_r.timeout_flag_n = 1'b1;
          next_r.powerdown_flag_n = 1'b1;
        end
      end
      swr_pkg::SWR_SLEEP:
      begin
        // io_q and oe_q keep their pre-sleep value here
        if (wake_any)
        begin
          next_r.state = swr_pkg::SWR_WAKE_RST;
          next_r.wait_cnt = 16'h0000;
          next_r.wake_change_flag = pin_change && !master_clear_pin_reset && !wdt_timeout;
          if (wdt_timeout)
          begin
            next_r.timeout_flag_n = 1'b0;
          end
        end
      end
      swr_pkg::SWR_WAKE_RST:
      begin
        // Stay in reset while the pin is still held low
        if (r.wait_cnt < 16'(swr_pkg::RESET_PULSE_CYCLES - 1) || master_clear_pin_reset)
        begin
          next_r.wait_cnt = r.wait_cnt + 16'h0001;
        end
        else
        begin
          next_r.state = swr_pkg::SWR_OSC_START;
          next_r.wait_cnt = 16'h0000;
        end
      end
      swr_pkg::SWR_OSC_START:
      begin
        // Core waits for a running clock before the first fetch
        if (r.wait_cnt == 16'(OSC_CYCLES - 1))
        begin
          next_r.state = swr_pkg::SWR_RUN;
        end
        else
        begin
          next_r.wait_cnt = r.wait_cnt + 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      r <= '0;
      r.state <= swr_pkg::SWR_RUN;
      r.timeout_flag_n <= swr_pkg::TO_N_RESET;
      r.powerdown_flag_n <= swr_pkg::PD_N_RESET;
      r.master_clear_pin_s1 <= 1'b1;
      r.master_clear_pin_s2 <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign io_out = r.io_q;
  assign io_oe_out = r.oe_q;
  assign master_clear_oe_out = r.master_clear_pin_oe;
  assign osc_drive_en_out = (r.state != swr_pkg::SWR_SLEEP);
  assign sleeping_out = (r.state == swr_pkg::SWR_SLEEP);
  assign device_reset_out = (r.state == swr_pkg::SWR_WAKE_RST);
  assign core_hold_out = (r.state != swr_pkg::SWR_RUN);
  assign timeout_flag_n_out = r.timeout_flag_n;
  assign powerdown_flag_n_out = r.powerdown_flag_n;
  assign wake_change_flag_out = r.wake_change_flag;
  always_comb
  begin
    status_out = 8'h00;
    status_out[swr_pkg::STATUS_TO_BIT] = r.timeout_flag_n;
    status_out[swr_pkg::STATUS_PD_BIT] = r.powerdown_flag_n;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  // Hold cycles after the reset pulse; the count must track OSC_CYCLES, not a fixed figure
  logic [15:0] hold_len;
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      hold_len <= 16'h0000;
    end
    else if (device_reset_out || !core_hold_out)
    begin
      hold_len <= 16'h0000;
    end
    else
    begin
      hold_len <= hold_len + 16'h0001;
    end
  end

  a_sleep_entry: assert property (
    r.state == swr_pkg::SWR_RUN && sleep_instr_in && !master_clear_pin_reset && !wdt_timeout
    |=> sleeping_out && !osc_drive_en_out)
    else $error("sleep not entered");
  a_sleep_flags: assert property (
    r.state == swr_pkg::SWR_RUN && sleep_instr_in && !master_clear_pin_reset && !wdt_timeout
    |=> timeout_flag_n_out && !powerdown_flag_n_out && status_out == 8'h10)
    else $error("flags wrong after sleep entry");
  a_pins_held: assert property (
    sleeping_out [*2] |-> $stable(io_out) && $stable(io_oe_out))
    else $error("pins changed during sleep");
  a_master_clear_pin_quiet: assert property (
    wdt_timeout |-> ##[0:3] !master_clear_oe_out)
    else $error("master clear driven");
  a_pin_wake: assert property (
    sleeping_out && pin_change && !master_clear_pin_reset && !wdt_timeout
    |=> device_reset_out && wake_change_flag_out)
    else $error("pin change did not wake");
  a_wake_restart: assert property (
    sleeping_out && wake_any && master_clear_pin_n_in
    |=> device_reset_out [*2] ##1 (core_hold_out && osc_drive_en_out) ##[1:1000] !core_hold_out)
    else $error("wake did not restart");
  a_timeout_flag: assert property (
    wdt_timeout && r.state inside {swr_pkg::SWR_RUN, swr_pkg::SWR_SLEEP}
    |=> !timeout_flag_n_out)
    else $error("timeout flag not cleared");
  a_wake_wdt_clear: assert property (
    $rose(device_reset_out) |-> wdt_bus.clear ##1 (wdt_bus.clear || !device_reset_out))
    else $error("watchdog not cleared on wake");
  a_clear_flags: assert property (
    r.state == swr_pkg::SWR_RUN && watchdog_clear_instr_in && !sleep_instr_in
    && !master_clear_pin_reset && !wdt_timeout |=> timeout_flag_n_out && powerdown_flag_n_out)
    else $error("clear instruction flags wrong");
  a_osc_hold: assert property (
    $fell(core_hold_out) |-> hold_len == 16'(OSC_CYCLES))
    else $error("execution released too early");

  c_pin_wake: cover property (sleeping_out && pin_change ##1 device_reset_out);
  c_wdt_wake: cover property (sleeping_out && wdt_timeout ##1 !timeout_flag_n_out);
  c_master_clear_pin_wake: cover property (sleeping_out && master_clear_pin_reset ##1 device_reset_out);
  c_rewake: cover property (wake_change_flag_out && sleep_instr_in ##1 sleeping_out ##1 device_reset_out);

endmodule

`default_nettype wire

// >>> tb/swr_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Reset switch and wake pin source
// ----------------------------------------
module swr_pin_model (
  input wire logic mclk_in,
  input wire logic master_clear_pin_low_in,
  input wire logic [3:0] pins_in,
  output logic master_clear_pin_n_out,
  output logic [3:0] wake_pins_out
);
  // Levels move just after an edge, like a slow board signal
  always @(posedge mclk_in)
  begin
    master_clear_pin_n_out <= ~master_clear_pin_low_in;
    wake_pins_out <= pins_in;
  end
endmodule

`default_nettype wire

// >>> tb/swr_sleep_wake_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin fail_count++; \
  $display("Error %s expected %0h seen %0h", nm, ex, gt); end end

module swr_sleep_wake_tb;
  localparam int OSC = 4;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic slp = 1'b0, clr = 1'b0, acc = 1'b0, mce = 1'b1, wde = 1'b0, woc = 1'b0;
  logic master_clear_pin_low = 1'b0, pta = 1'b0;
  logic [2:0] psel = 3'h0;
  logic [3:0] pins = 4'h0, wp;
  logic mcn, mcoe, osc, slpg, drst, hold, to_n, pd_n, wcf;
  logic [7:0] cio = 8'hA5, coe = 8'h0F, io, ioe, st;
  int fail_count = 0, samples_checked = 0, cyc = 0;

  // ----------------------------------------
  // Design and pin source
  // ----------------------------------------
  swr_sleep_wake #(.OSC_CYCLES(OSC), .WDT_BASE(4)) i_swr_sleep_wake (
    .mclk_in(mclk_in), .reset_in(reset_in), .sleep_instr_in(slp),
    .watchdog_clear_instr_in(clr), .port_access_in(acc), .wake_pins_in(wp),
    .master_clear_pin_n_in(mcn), .master_clear_enable_in(mce),
    .watchdog_enable_in(wde), .wake_on_change_enable_in(woc),
    .prescaler_to_wdt_in(pta), .prescale_sel_in(psel), .core_io_in(cio),
    .core_io_oe_in(coe), .io_out(io), .io_oe_out(ioe), .master_clear_oe_out(mcoe),
    .osc_drive_en_out(osc), .sleeping_out(slpg), .device_reset_out(drst),
    .core_hold_out(hold), .timeout_flag_n_out(to_n), .powerdown_flag_n_out(pd_n),
    .wake_change_flag_out(wcf), .status_out(st));

  swr_pin_model i_swr_pin_model (.mclk_in(mclk_in), .master_clear_pin_low_in(master_clear_pin_low),
    .pins_in(pins), .master_clear_pin_n_out(mcn), .wake_pins_out(wp));

  // Free-running 40 MHz clock
  initial
  begin
    forever #12.5 mclk_in = ~mclk_in;
  end

  // Cycle ceiling well beyond the two watchdog periods the run needs
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      final_report();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  // One-cycle strobe: 0 sleep, 1 watchdog clear, 2 port access
  task automatic strobe(input int k);
    @(posedge mclk_in);
    case (k)
      0: slp <= 1'b1;
      1: clr <= 1'b1;
      default: acc <= 1'b1;
    endcase
    @(posedge mclk_in);
    {slp, clr, acc} <= 3'b000;
    #1;
  endtask

  // Waits for a wake reset, then times the oscillator hold
  task automatic wake_wait(input logic ewcf, input logic eto, input int lim);
    int n;
    n = 0;
    while (drst !== 1'b1 && n < lim)
    begin
      step(1);
      n++;
    end
    `CHK("wake reset", 1'b1, drst)
    `CHK("wake flag", ewcf, wcf)
    `CHK("clear pin drive", 1'b0, mcoe)
    n = 0;
    while (drst === 1'b1 && n < 50)
    begin
      step(1);
      n++;
    end
    `CHK("osc restart", 1'b1, osc)
    n = 0;
    while (hold === 1'b1 && n < 50)
    begin
      step(1);
      n++;
    end
    `CHK("hold cycles", OSC, n)
    `CHK("timeout flag", eto, to_n)
  endtask

  task automatic final_report;
    $display("Checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    `CHK("status", 8'h18, st)
    `CHK("wake flag", 1'b0, wcf)
    `CHK("osc", 1'b1, osc)
    `CHK("powerdown flag", 1'b1, pd_n)
    `CHK("hold", 1'b0, hold)
  endtask

  // Sleep entry with pins frozen; change ignored until enabled
  task automatic t_sleep;
    strobe(2);
    strobe(0);
    `CHK("sleeping", 1'b1, slpg)
    `CHK("osc off", 1'b0, osc)
    `CHK("status", 8'h10, st)
    `CHK("powerdown flag", 1'b0, pd_n)
    cio <= 8'h3C;
    coe <= 8'hF0;
    pins <= 4'h9;
    step(20);
    `CHK("io", 8'hA5, io)
    `CHK("io enable", 8'h0F, ioe)
    `CHK("no wake", 1'b1, slpg)
    woc <= 1'b1;
    wake_wait(1'b1, 1'b1, 10);
  endtask

  // Reference comes from the last port read, not sleep entry
  task automatic t_pins;
    pins <= 4'h3;
    step(3);
    strobe(2);
    strobe(0);
    step(20);
    `CHK("steady pins", 1'b1, slpg)
    pins <= 4'h2;
    wake_wait(1'b1, 1'b1, 10);
    strobe(0);
    wake_wait(1'b1, 1'b1, 5);
    strobe(2);
    pins <= 4'h7;
    step(3);
    strobe(0);
    wake_wait(1'b1, 1'b1, 5);
  endtask

  task automatic t_master_clear_pin;
    woc <= 1'b0;
    mce <= 1'b0;
    strobe(0);
    master_clear_pin_low <= 1'b1;
    step(8);
    `CHK("pin not reset", 1'b1, slpg)
    mce <= 1'b1;
    step(6);
    master_clear_pin_low <= 1'b0;
    wake_wait(1'b0, 1'b1, 10);
  endtask

  // A late pin wake must restart the watchdog count
  task automatic t_wdt_cleared;
    int seen;
    seen = 0;
    wde <= 1'b1;
    strobe(1);
    strobe(2);
    woc <= 1'b1;
    strobe(0);
    step(600);
    pins <= 4'h1;
    wake_wait(1'b1, 1'b1, 10);
    repeat (800)
    begin
      step(1);
      seen = seen | (drst === 1'b1);
    end
    `CHK("early timeout", 0, seen)
    wde <= 1'b0;
    step(1);
  endtask

  task automatic t_wdt_wake;
    woc <= 1'b0;
    wde <= 1'b1;
    strobe(0);
    wake_wait(1'b0, 1'b0, 1500);
    `CHK("status", 8'h00, st)
    strobe(1);
    `CHK("status", 8'h18, st)
    // Postscaler by two doubles the time-out, so no wake at the plain period
    pta <= 1'b1;
    strobe(0);
    step(1500);
    `CHK("postscaled sleep", 1'b1, slpg)
    wake_wait(1'b0, 1'b0, 700);
    pta <= 1'b0;
    wde <= 1'b0;
  endtask

  // Main sequence
  initial
  begin
    repeat (16) @(posedge mclk_in);
    reset_in <= 1'b0;
    step(3);
    t_reset();
    t_sleep();
    t_pins();
    t_master_clear_pin();
    t_wdt_cleared();
    t_wdt_wake();
    final_report();
  end
endmodule

`undef CHK
`default_nettype wire
